// *** design/pdcr_consts.vh ***
// Shared constants of the synthesizer divider and control register bank
`ifndef PDCR_CONSTS_VH
`define PDCR_CONSTS_VH

// ************************************************************
// Bus widths
// ************************************************************
`define PDCR_AW              8
`define PDCR_DW              8
`define PDCR_ZERO_BYTE       8'h00

// ************************************************************
// Register offsets
// ************************************************************
`define PDCR_ADDR_MDIV       8'h35
`define PDCR_ADDR_CTRL0      8'h38
`define PDCR_ADDR_STATUS     8'h39

// ************************************************************
// Field positions
// ************************************************************
`define PDCR_MDIV_MSB        4
`define PDCR_MDIV_LSB        0
`define PDCR_PDIV_MSB        4
`define PDCR_PDIV_LSB        2
`define PDCR_SYNC_BIT        1
`define PDCR_PDN_BIT         0
`define PDCR_ST_ACTIVE_BIT   0
`define PDCR_ST_BUSY_BIT     1
`define PDCR_ST_LOCK_BIT     2
`define PDCR_ST_TMO_BIT      3
`define PDCR_ST_PDN_BIT      4

// ************************************************************
// Reset values
// ************************************************************
`define PDCR_MDIV_RST        5'h00
`define PDCR_PDIV_RST        3'h7
`define PDCR_SYNC_RST        1'b1
`define PDCR_PDN_RST         1'b0

// ************************************************************
// Ratio decode
// ************************************************************
`define PDCR_M_BYPASS_CODE   5'h00
`define PDCR_M_STEP          6'h01
`define PDCR_P_TWO_CODE      3'h2
`define PDCR_P_MIN_RATIO     4'h2
`define PDCR_P_STEP          4'h1
`define PDCR_P_RST_RATIO     4'h8

// ************************************************************
// Timing
// ************************************************************
`define PDCR_CLK_MHZ         50
`define PDCR_CAL_TIMEOUT_US  100
`define PDCR_CAL_TIMEOUT_CYC 13'h1388
`define PDCR_CNT_W           13
`define PDCR_CNT_ONE         13'h0001
`define PDCR_CNT_ZERO        13'h0000

`endif

// *** design/pdcr_sync2.v ***
// Two-stage synchroniser for one level arriving from a pin
`timescale 1ns/1ps
module pdcr_sync2 (
  input  wire core_clk,
  input  wire reset_n,
  input  wire async_in,
  output wire sync_out
);

  reg meta_reg;
  reg sync_reg;

  // First stage feeds only the second stage
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

// *** design/pdcr_ratio_decode.v ***
// Combinational decode of divider codes into division ratios
`timescale 1ns/1ps
`include "pdcr_consts.vh"
module pdcr_ratio_decode (
  input  wire [4:0] m_code,
  input  wire [2:0] p_code,
  output wire       m_bypass,
  output wire [5:0] m_ratio,
  output wire [3:0] p_ratio
);

  // Code zero bypasses, code n divides by n plus one
  function [5:0] pdcr_m_ratio;
    input [4:0] code;
    begin
      if (code == `PDCR_M_BYPASS_CODE) begin
        pdcr_m_ratio = `PDCR_M_STEP;
      end else begin
        pdcr_m_ratio = {1'b0, code} + `PDCR_M_STEP;
      end
    end
  endfunction

  // Codes 0 and 1 both give two, others give code plus one
  function [3:0] pdcr_p_ratio;
    input [2:0] code;
    begin
      if (code < `PDCR_P_TWO_CODE) begin
        pdcr_p_ratio = `PDCR_P_MIN_RATIO;
      end else begin
        pdcr_p_ratio = {1'b0, code} + `PDCR_P_STEP;
      end
    end
  endfunction

  // Decoded ratios
  assign m_bypass = (m_code == `PDCR_M_BYPASS_CODE); // [R1]
  assign m_ratio  = pdcr_m_ratio(m_code);            // [R1]
  assign p_ratio  = pdcr_p_ratio(p_code);            // [R2]

endmodule

// *** design/pll_divider_control_regs.v ***
// Divider and control register bank with power-down and calibration sequencing
//
// Operation
// [R1] M code zero bypasses, n divides n+1
// [R2] Post codes 0,1 divide two; else code+1
// [R3] Sync enable selects synthesizer for resync
// [R4] After reset, power-up and calibrate automatically
// [R5] Power-down set disables synth, resets calibration
// [R6] Power-down cleared re-enables, restarts calibration
// [R7] Bits 7:5 read zero, writes ignored
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "pdcr_consts.vh"
module pll_divider_control_regs #(
  // Calibration wait in core clock cycles, 100 us at 50 MHz
  parameter [`PDCR_CNT_W-1:0] CAL_TIMEOUT_CYC = `PDCR_CAL_TIMEOUT_CYC
) (
  input  wire       core_clk,
  input  wire       reset_n,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wr_data,
  input  wire       reg_wr_en,
  input  wire       reg_rd_en,
  output wire [7:0] reg_rd_data,
  input  wire       cal_done_pin,
  output wire [4:0] ref_path_divider_code,
  output wire       m_div_bypass,
  output wire [5:0] m_div_ratio,
  output wire [2:0] post_div_code,
  output wire [3:0] post_div_ratio,
  output wire       sync_src_synth,
  output wire       synth_enable,
  output wire       cal_circuit_reset,
  output wire       cal_start,
  output wire       cal_busy,
  output wire       cal_locked,
  output wire       cal_timeout
);

  // ************************************************************
  // Sequencer states
  // ************************************************************
  localparam [4:0] S_OFF   = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_CAL   = 5'h04;
  localparam [4:0] S_LOCK  = 5'h08;
  localparam [4:0] S_FAIL  = 5'h10;

  // ************************************************************
  // Declarations
  // ************************************************************
  reg  [4:0]             mdiv_reg;
  reg  [4:0]             mdiv_next;
  reg  [2:0]             pdiv_reg;
  reg  [2:0]             pdiv_next;
  reg                    sync_en_reg;
  reg                    sync_en_next;
  reg                    synth_power_down_reg;
  reg                    synth_power_down_next;
  reg  [4:0]             state_reg;
  reg  [4:0]             state_next;
  reg  [`PDCR_CNT_W-1:0] cnt_reg;
  reg  [`PDCR_CNT_W-1:0] cnt_next;
  reg  [7:0]             rd_data_reg;
  reg  [7:0]             rd_data_next;
  reg                    synth_en_reg;
  reg                    cal_rst_reg;
  reg                    cal_busy_reg;
  reg  [5:0]             m_ratio_reg;
  reg                    m_bypass_reg;
  reg  [3:0]             p_ratio_reg;
  wire                   cal_done_sync;
  wire                   m_bypass_dec;
  wire [5:0]             m_ratio_dec;
  wire [3:0]             p_ratio_dec;
  wire                   wr_mdiv;
  wire                   wr_ctrl0;
  wire                   cnt_expired;
  wire [7:0]             mdiv_view;
  wire [7:0]             ctrl0_view;
  wire [7:0]             status_view;

  // ************************************************************
  // Pin synchronisation
  // ************************************************************

  // Calibration done level from the analog loop
  pdcr_sync2 u_done_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in (cal_done_pin),
    .sync_out (cal_done_sync)
  );

  // ************************************************************
  // Ratio decode
  // ************************************************************

  // Decode the stored codes into ratios
  pdcr_ratio_decode u_decode (
    .m_code   (mdiv_reg),
    .p_code   (pdiv_reg),
    .m_bypass (m_bypass_dec),
    .m_ratio  (m_ratio_dec),
    .p_ratio  (p_ratio_dec)
  );

  // ************************************************************
  // Register writes
  // ************************************************************

  // Address decode of the write strobe
  assign wr_mdiv  = reg_wr_en && (reg_addr == `PDCR_ADDR_MDIV);
  assign wr_ctrl0 = reg_wr_en && (reg_addr == `PDCR_ADDR_CTRL0);

  // Next values; only the low field bits are taken
  always @* begin
    mdiv_next             = mdiv_reg;
    pdiv_next             = pdiv_reg;
    sync_en_next          = sync_en_reg;
    synth_power_down_next = synth_power_down_reg;
    if (wr_mdiv) begin
      mdiv_next = reg_wr_data[`PDCR_MDIV_MSB:`PDCR_MDIV_LSB]; // [R1] [R7]
    end
    if (wr_ctrl0) begin
      pdiv_next             = reg_wr_data[`PDCR_PDIV_MSB:`PDCR_PDIV_LSB]; // [R2] [R7]
      sync_en_next          = reg_wr_data[`PDCR_SYNC_BIT]; // [R3]
      synth_power_down_next = reg_wr_data[`PDCR_PDN_BIT];  // [R5] [R6]
    end
  end

  // Configuration flops with documented reset values
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mdiv_reg             <= `PDCR_MDIV_RST; // [R1]
      pdiv_reg             <= `PDCR_PDIV_RST; // [R2]
      sync_en_reg          <= `PDCR_SYNC_RST; // [R3]
      synth_power_down_reg <= `PDCR_PDN_RST;  // [R4]
    end else begin
      mdiv_reg             <= mdiv_next;
      pdiv_reg             <= pdiv_next;
      sync_en_reg          <= sync_en_next;
      synth_power_down_reg <= synth_power_down_next;
    end
  end

  // ************************************************************
  // Calibration sequencer
  // ************************************************************

  // Timeout reached while waiting for the loop
  assign cnt_expired = (cnt_reg >= CAL_TIMEOUT_CYC);

  // Power-down forces the off state from anywhere
  always @* begin
    state_next = state_reg;
    if (synth_power_down_reg) begin
      state_next = S_OFF; // [R5]
    end else begin
      case (state_reg)
        S_OFF: begin
          state_next = S_START; // [R4] [R6]
        end
        S_START: begin
          state_next = S_CAL;
        end
        S_CAL: begin
          // Done wins over a timeout in the same cycle
          if (cal_done_sync) begin
            state_next = S_LOCK;
          end else if (cnt_expired) begin
            state_next = S_FAIL;
          end
        end
        S_LOCK: begin
          state_next = S_LOCK;
        end
        S_FAIL: begin
          state_next = S_FAIL;
        end
        default: begin
          state_next = S_OFF;
        end
      endcase
    end
  end

  // Wait counter runs only while calibrating
  always @* begin
    cnt_next = `PDCR_CNT_ZERO;
    // Clears to zero at the timeout so it cannot wrap
    if ((state_reg == S_CAL) && !cnt_expired) begin
      cnt_next = cnt_reg + `PDCR_CNT_ONE;
    end
  end

  // Sequencer flops; reset lands in off, then starts by itself
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_OFF; // [R4]
      cnt_reg   <= `PDCR_CNT_ZERO;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // Registered controls toward the analog loop
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      synth_en_reg <= 1'b0;
      cal_rst_reg  <= 1'b1;
      cal_busy_reg <= 1'b0;
    end else begin
      synth_en_reg <= (state_next != S_OFF);  // [R5] [R6]
      cal_rst_reg  <= (state_next == S_OFF);  // [R5]
      cal_busy_reg <= (state_next == S_START) || (state_next == S_CAL);
    end
  end

  // ************************************************************
  // Registered ratio outputs
  // ************************************************************

  // Ratios follow the codes one cycle later
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      m_ratio_reg  <= `PDCR_M_STEP;
      m_bypass_reg <= 1'b1;
      p_ratio_reg  <= `PDCR_P_RST_RATIO; // Ratio of the reset code
    end else begin
      m_ratio_reg  <= m_ratio_dec;  // [R1]
      m_bypass_reg <= m_bypass_dec; // [R1]
      p_ratio_reg  <= p_ratio_dec;  // [R2]
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************

  // Read views with upper bits forced low
  assign mdiv_view   = {3'h0, mdiv_reg}; // [R7]
  assign ctrl0_view  = {3'h0, pdiv_reg, sync_en_reg, synth_power_down_reg}; // [R7]

  // Status: power-down, fail, lock, busy, enable
  assign status_view = {3'h0,
                        synth_power_down_reg,
                        (state_reg == S_FAIL),
                        (state_reg == S_LOCK),
                        cal_busy_reg,
                        synth_en_reg};

  // Read data only in the cycle after the strobe
  always @* begin
    rd_data_next = `PDCR_ZERO_BYTE;
    if (reg_rd_en) begin
      case (reg_addr)
        `PDCR_ADDR_MDIV: begin
          rd_data_next = mdiv_view;
        end
        `PDCR_ADDR_CTRL0: begin
          rd_data_next = ctrl0_view;
        end
        `PDCR_ADDR_STATUS: begin
          rd_data_next = status_view;
        end
        default: begin
          rd_data_next = `PDCR_ZERO_BYTE;
        end
      endcase
    end
  end

  // Read data flop
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg <= `PDCR_ZERO_BYTE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // All outputs but cal_start, cal_locked and cal_timeout come straight from flops
  assign reg_rd_data           = rd_data_reg;
  assign ref_path_divider_code = mdiv_reg;
  assign m_div_bypass          = m_bypass_reg;
  assign m_div_ratio           = m_ratio_reg;
  assign post_div_code         = pdiv_reg;
  assign post_div_ratio        = p_ratio_reg;
  assign sync_src_synth        = sync_en_reg; // [R3]
  assign synth_enable          = synth_en_reg;
  assign cal_circuit_reset     = cal_rst_reg;
  assign cal_busy              = cal_busy_reg;

  // Sequencer flags decoded from the one-hot state
  assign cal_start             = (state_reg == S_START); // One-cycle pulse
  assign cal_locked            = (state_reg == S_LOCK);
  assign cal_timeout           = (state_reg == S_FAIL);

endmodule

// *** tb/pdcr_checker.sv ***
// Port-level assertions for the divider and control register bank
`timescale 1ns/1ps
module pdcr_checker #(
  parameter [12:0] CAL_TIMEOUT_CYC = 13'h1388
) (
  input logic       core_clk,
  input logic       reset_n,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wr_data,
  input logic       reg_wr_en,
  input logic       reg_rd_en,
  input logic [7:0] reg_rd_data,
  input logic       cal_done_pin,
  input logic [4:0] ref_path_divider_code,
  input logic       m_div_bypass,
  input logic [5:0] m_div_ratio,
  input logic [2:0] post_div_code,
  input logic [3:0] post_div_ratio,
  input logic       sync_src_synth,
  input logic       synth_enable,
  input logic       cal_circuit_reset,
  input logic       cal_start,
  input logic       cal_busy,
  input logic       cal_locked,
  input logic       cal_timeout
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [13:0] busy_cnt_reg;
  // Length of the current busy run
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_reg <= 14'h0000;
    end else begin
      busy_cnt_reg <= cal_busy ? busy_cnt_reg + 14'h0001 : 14'h0000;
    end
  end
  a_m_decode: assert property (
    $past(reset_n) |-> m_div_bypass == ($past(ref_path_divider_code) == 5'h00) &&
    m_div_ratio == (($past(ref_path_divider_code) == 5'h00) ? 6'h01 :
    {1'b0, $past(ref_path_divider_code)} + 6'h01)) else $error("M decode wrong");
  a_p_decode: assert property (
    $past(reset_n) |-> post_div_ratio == (($past(post_div_code) < 3'h2) ? 4'h2 :
    {1'b0, $past(post_div_code)} + 4'h1)) else $error("Post decode wrong");
  a_rd_top_zero: assert property (
    $past(reg_rd_en) |-> reg_rd_data[7:5] == 3'h0) else $error("Upper read bits set");
  a_rd_m_field: assert property (
    $past(reg_rd_en) && $past(reg_addr) == 8'h35 |->
    reg_rd_data[4:0] == $past(ref_path_divider_code)) else $error("M readback wrong");
  a_rd_ctrl_field: assert property (
    $past(reg_rd_en) && $past(reg_addr) == 8'h38 |-> reg_rd_data[4:1] ==
    {$past(post_div_code), $past(sync_src_synth)}) else $error("Control readback wrong");
  a_off_state: assert property (
    !synth_enable |-> cal_circuit_reset && !cal_busy && !cal_locked && !cal_timeout)
    else $error("Off state outputs wrong");
  a_pdn_set: assert property (
    reg_wr_en && reg_addr == 8'h38 && reg_wr_data[0] |-> ##[1:3] !synth_enable)
    else $error("Power-down ignored");
  a_cal_restart: assert property (
    $fell(cal_circuit_reset) |-> cal_start && synth_enable && cal_busy)
    else $error("Calibration did not start");
  a_start_pulse: assert property (
    cal_start |=> !cal_start) else $error("Start pulse too long");
  a_cal_bounded: assert property (
    busy_cnt_reg <= {1'b0, CAL_TIMEOUT_CYC} + 14'h0004) else $error("Calibration hangs");
  a_lock_holds: assert property (
    cal_locked |=> cal_locked || !synth_enable) else $error("Lock dropped");
endmodule
bind pll_divider_control_regs pdcr_checker #(
  .CAL_TIMEOUT_CYC (CAL_TIMEOUT_CYC)
) chk_u (
  .core_clk              (core_clk),
  .reset_n               (reset_n),
  .reg_addr              (reg_addr),
  .reg_wr_data           (reg_wr_data),
  .reg_wr_en             (reg_wr_en),
  .reg_rd_en             (reg_rd_en),
  .reg_rd_data           (reg_rd_data),
  .cal_done_pin          (cal_done_pin),
  .ref_path_divider_code (ref_path_divider_code),
  .m_div_bypass          (m_div_bypass),
  .m_div_ratio           (m_div_ratio),
  .post_div_code         (post_div_code),
  .post_div_ratio        (post_div_ratio),
  .sync_src_synth        (sync_src_synth),
  .synth_enable          (synth_enable),
  .cal_circuit_reset     (cal_circuit_reset),
  .cal_start             (cal_start),
  .cal_busy              (cal_busy),
  .cal_locked            (cal_locked),
  .cal_timeout           (cal_timeout)
);

// *** tb/pll_divider_control_regs_tb_top.sv ***
// Self-checking bench for the divider and control register bank
`timescale 1ns/1ps
module pll_divider_control_regs_tb_top;
  localparam int TMO = 20;
  logic       core_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic       reg_wr_en = 1'b0;
  logic       reg_rd_en = 1'b0;
  logic       cal_done_pin = 1'b0;
  wire  [7:0] reg_rd_data;
  wire  [4:0] ref_path_divider_code;
  wire  [5:0] m_div_ratio;
  wire  [2:0] post_div_code;
  wire  [3:0] post_div_ratio;
  wire        m_div_bypass, sync_src_synth, synth_enable, cal_circuit_reset;
  wire        cal_start, cal_busy, cal_locked, cal_timeout;
  wire  [2:0] evts = {cal_timeout, cal_locked, cal_start};
  logic [7:0] rd_q[$];
  logic       rd_pend = 1'b0;
  logic [7:0] m_reg, c_reg, addr_v;
  int         num_errors = 0;
  int         checked = 0;
  int         cycles = 0;

  always #10 core_clk = ~core_clk;

  pll_divider_control_regs #(
    .CAL_TIMEOUT_CYC (13'(TMO))
  ) dut_u (
    .core_clk              (core_clk),
    .reset_n               (reset_n),
    .reg_addr              (reg_addr),
    .reg_wr_data           (reg_wr_data),
    .reg_wr_en             (reg_wr_en),
    .reg_rd_en             (reg_rd_en),
    .reg_rd_data           (reg_rd_data),
    .cal_done_pin          (cal_done_pin),
    .ref_path_divider_code (ref_path_divider_code),
    .m_div_bypass          (m_div_bypass),
    .m_div_ratio           (m_div_ratio),
    .post_div_code         (post_div_code),
    .post_div_ratio        (post_div_ratio),
    .sync_src_synth        (sync_src_synth),
    .synth_enable          (synth_enable),
    .cal_circuit_reset     (cal_circuit_reset),
    .cal_start             (cal_start),
    .cal_busy              (cal_busy),
    .cal_locked            (cal_locked),
    .cal_timeout           (cal_timeout)
  );

  task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    cmp_port(got, exp);
  endtask
  function automatic logic [7:0] rd_exp(input logic [7:0] a);
    return (a == 8'h35) ? m_reg : (a == 8'h38) ? c_reg : 8'h00;
  endfunction
  // ****
  // Bus master
  // ****
  // Strobes rise at a clock edge and are sampled at the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    reg_rd_en <= 1'b0;
    if (a == 8'h35) m_reg = {3'h0, d[4:0]};
    if (a == 8'h38) c_reg = {3'h0, d[4:0]};
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    rd_q.push_back(e);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    reg_wr_en <= 1'b0;
  endtask
  task automatic idle(input int n);
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_hi(input int sel, input int lim);
    int n;
    n = 0;
    while (evts[sel] !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    cmp_port({7'h00, evts[sel]}, 8'h01);
  endtask
  task automatic chk_ports();
    cmp_port({3'h0, ref_path_divider_code}, m_reg);
    cmp_port({7'h00, m_div_bypass}, {7'h00, m_reg == 8'h00});
    cmp_port({2'h0, m_div_ratio}, (m_reg == 8'h00) ? 8'h01 : m_reg + 8'h01);
    cmp_port({5'h00, post_div_code}, {5'h00, c_reg[4:2]});
    cmp_port({4'h0, post_div_ratio}, (c_reg[4:2] < 3'h2) ? 8'h02 : c_reg[4:2] + 8'h01);
    cmp_port({7'h00, sync_src_synth}, {7'h00, c_reg[1]});
  endtask
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Read data watcher, oldest note first
  always @(posedge core_clk) begin
    if (rd_pend) cmp_rd(reg_rd_data, rd_q.pop_front());
    rd_pend <= reg_rd_en;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(89227));
    m_reg = 8'h00;
    c_reg = 8'h1e;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_hi(0, 4);
    cmp_port({6'h00, synth_enable, cal_circuit_reset}, 8'h02);
    rd(8'h35, 8'h00);
    rd(8'h38, 8'h1e);
    idle(1);
    chk_ports();
    @(posedge core_clk);
    cal_done_pin <= 1'b1;
    #1;
    wait_hi(1, 8);
    rd(8'h39, 8'h05);
    wr(8'h38, 8'hff);
    rd(8'h38, 8'h1f);
    idle(3);
    cmp_port({5'h00, synth_enable, cal_circuit_reset, cal_locked}, 8'h02);
    rd(8'h39, 8'h10);
    cal_done_pin <= 1'b0;
    wr(8'h38, 8'h1e);
    idle(1);
    wait_hi(0, 6);
    cmp_port({6'h00, cal_busy, cal_circuit_reset}, 8'h02);
    wait_hi(2, TMO + 10);
    rd(8'h39, 8'h09);
    for (int i = 0; i < 32; i++) begin
      wr(8'h35, {3'($urandom), i[4:0]});
      wr(8'h38, {3'($urandom), i[2:0], 1'($urandom), 1'b0});
      rd(8'h35, rd_exp(8'h35));
      rd(8'h38, rd_exp(8'h38));
      idle(2);
      chk_ports();
    end
    for (int i = 0; i < 8; i++) begin
      addr_v = {2'h1, 6'($urandom)};
      wr(addr_v, 8'($urandom));
      rd(addr_v, 8'h00);
    end
    wr(8'h39, 8'hff);
    rd(8'h35, rd_exp(8'h35));
    rd(8'h38, rd_exp(8'h38));
    idle(2);
    @(posedge core_clk);
    reset_n <= 1'b0;
    m_reg = 8'h00;
    c_reg = 8'h1e;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    wait_hi(0, 4);
    rd(8'h35, 8'h00);
    rd(8'h38, 8'h1e);
    idle(2);
    chk_ports();
    end_of_test();
  end
endmodule
